//--- src/ctm_pkg.sv
// Purpose: constants for the CAN operating-mode control block
// Assumes: 200 MHz ref_clk, APB register access
// Notes:   all offsets, fields, resets and timing counts live here
// Operation
// - loopback returns every transmitted frame to own receive path
// - loopback routes controller transmit output internally to its receive input
// - silent mode only receives; never drives frames or acknowledge bits
// - silent loopback self-tests on live bus without disturbing other nodes
// - single-attempt mode: no automatic retransmission, each frame tried once
// - interface up: ready lamp on, host-state lamp off
// - interface down: host-state lamp on, ready lamp off
// - transmitting while enabled: ready lamp on, host-state lamp blinks
// - ready lamp blinks fast when error-passive, slow when error-warning
// - bus-off: host-state lamp blinks slowly
`default_nettype none

package ctm_pkg;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [11:0] ctm_off_ctrl   = 12'h000;
	localparam logic [11:0] ctm_off_timing = 12'h004;
	localparam logic [11:0] ctm_off_status = 12'h008;
	localparam logic [11:0] ctm_off_irq    = 12'h00C;
	localparam logic [11:0] ctm_off_mask   = 12'h010;

	// ----------------------------------------
	// control fields
	// ----------------------------------------
	localparam int ctm_ctrl_enable   = 0;
	localparam int ctm_ctrl_loopback = 1;
	localparam int ctm_ctrl_silent   = 2;
	localparam int ctm_ctrl_oneshot  = 3;
	localparam int ctm_ctrl_width    = 4;

	// ----------------------------------------
	// timing fields: bit-rate prescaler and sample point
	// ----------------------------------------
	localparam int ctm_tim_brp_lsb = 0;
	localparam int ctm_tim_brp_w   = 16;
	localparam int ctm_tim_sp_lsb  = 16;
	localparam int ctm_tim_sp_w    = 8;
	localparam int unsigned ctm_tim_brp_reset = 1600;
	localparam int unsigned ctm_tim_sp_reset  = 224;

	// ----------------------------------------
	// interrupt bits
	// ----------------------------------------
	localparam int ctm_irq_tx_done = 0;
	localparam int ctm_irq_tx_fail = 1;
	localparam int ctm_irq_err_chg = 2;
	localparam int ctm_irq_width   = 3;

	// ----------------------------------------
	// lamp blink timing
	// ----------------------------------------
	localparam int unsigned ctm_clk_mhz      = 200;
	localparam int unsigned ctm_fast_ms      = 50;
	localparam int unsigned ctm_slow_ms      = 500;
	localparam int unsigned ctm_fast_cycles  = ctm_fast_ms * ctm_clk_mhz * 1000;
	localparam int unsigned ctm_slow_cycles  = ctm_slow_ms * ctm_clk_mhz * 1000;
	localparam int ctm_blink_w = 27;

	// ----------------------------------------
	// bus error states
	// ----------------------------------------
	typedef enum logic [1:0] {
		ctm_err_active  = 2'b00,
		ctm_err_warning = 2'b01,
		ctm_err_passive = 2'b11,
		ctm_err_busoff  = 2'b10
	} ctm_err_type;

	// ----------------------------------------
	// transmit sequencing
	// ----------------------------------------
	typedef enum logic [1:0] {
		ctm_tx_idle = 2'b00,
		ctm_tx_busy = 2'b01,
		ctm_tx_done = 2'b11
	} ctm_tx_state_type;

endpackage : ctm_pkg

`default_nettype wire

//--- src/ctm_mode_ctrl.sv
// Purpose: operating-mode, test-mode and lamp control around a CAN controller core
// Assumes: core handles bit timing and framing; all inputs synchronous to ref_clk
// Notes:   mode bits are latched into the active set only while the interface is down
`default_nettype none

module ctm_mode_ctrl #(
	parameter int unsigned fast_cycles = ctm_pkg::ctm_fast_cycles,
	parameter int unsigned slow_cycles = ctm_pkg::ctm_slow_cycles
) (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	// controller core side
	input  wire logic        core_tx,
	input  wire logic        core_tx_req,
	input  wire logic        core_tx_ok,
	input  wire logic        core_tx_err,
	input  wire logic [1:0]  core_err_state,
	output var  logic        core_rx,
	output var  logic        core_enable,
	output var  logic        core_retry_abort,
	output var  logic        core_ack_inhibit,
	output var  logic [15:0] core_brp,
	output var  logic [7:0]  core_sample_point,
	// bus transceiver pins
	output var  logic        can_tx,
	input  wire logic        can_rx,
	// lamps and interrupt
	output var  logic        lamp_ready,
	output var  logic        lamp_host,
	output var  logic        irq
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [ctm_pkg::ctm_ctrl_width-1:0] ctrl;
	logic [ctm_pkg::ctm_ctrl_width-1:0] active;
	logic [15:0]                        brp;
	logic [7:0]                         sp;
	logic [ctm_pkg::ctm_irq_width-1:0]  irq_status;
	logic [ctm_pkg::ctm_irq_width-1:0]  irq_mask;
	ctm_pkg::ctm_tx_state_type          tx_state;
	logic [1:0]                         err_prev;
	logic [ctm_pkg::ctm_blink_w-1:0]    fast_cnt;
	logic [ctm_pkg::ctm_blink_w-1:0]    slow_cnt;
	logic                               fast_phase;
	logic                               slow_phase;

	logic        wr_en;
	logic        rd_en;
	logic        wr_take;
	logic        loop_mode;
	logic        silent_mode;
	logic [ctm_pkg::ctm_irq_width-1:0] irq_events;
	logic [ctm_pkg::ctm_irq_width-1:0] next_irq_status;
	logic        next_lamp_ready;
	logic        next_lamp_host;

	// ----------------------------------------
	// access decode
	// ----------------------------------------
	function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
		addr_hit = (a == off);
	endfunction : addr_hit

	assign wr_en       = psel && penable && pwrite;
	assign rd_en       = psel && !penable && !pwrite;
	// writes land at the access edge, when pready is sampled high
	assign wr_take     = wr_en && pready;
	assign loop_mode   = active[ctm_pkg::ctm_ctrl_loopback];
	// both set collapses to silent loopback
	assign silent_mode = active[ctm_pkg::ctm_ctrl_silent];

	// ----------------------------------------
	// apb access: zero wait states
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			// unmapped offsets answer with an error; writes there are dropped
			pslverr <= psel && !penable && !(addr_hit(paddr, ctm_pkg::ctm_off_ctrl)
				|| addr_hit(paddr, ctm_pkg::ctm_off_timing) || addr_hit(paddr, ctm_pkg::ctm_off_status)
				|| addr_hit(paddr, ctm_pkg::ctm_off_irq) || addr_hit(paddr, ctm_pkg::ctm_off_mask));
		end
	end

	// ----------------------------------------
	// apb read data: captured in the setup cycle
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			prdata <= 32'h0000_0000;
			if (addr_hit(paddr, ctm_pkg::ctm_off_ctrl))
				prdata[ctm_pkg::ctm_ctrl_width-1:0] <= ctrl;
			if (addr_hit(paddr, ctm_pkg::ctm_off_timing))
				prdata[23:0] <= {sp, brp};
			if (addr_hit(paddr, ctm_pkg::ctm_off_status))
				prdata[7:0] <= {err_prev, tx_state, active};
			if (addr_hit(paddr, ctm_pkg::ctm_off_irq))
				prdata[ctm_pkg::ctm_irq_width-1:0] <= irq_status;
			if (addr_hit(paddr, ctm_pkg::ctm_off_mask))
				prdata[ctm_pkg::ctm_irq_width-1:0] <= irq_mask;
		end
	end

	// ----------------------------------------
	// control and timing registers
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ctrl <= '0;
			brp  <= 16'(ctm_pkg::ctm_tim_brp_reset);
			sp   <= 8'(ctm_pkg::ctm_tim_sp_reset);
		end else if (wr_take) begin
			if (addr_hit(paddr, ctm_pkg::ctm_off_ctrl))
				ctrl <= pwdata[ctm_pkg::ctm_ctrl_width-1:0];
			// timing is frozen while up; host must program it first
			if (addr_hit(paddr, ctm_pkg::ctm_off_timing) && !active[ctm_pkg::ctm_ctrl_enable]) begin
				brp <= pwdata[ctm_pkg::ctm_tim_brp_lsb +: ctm_pkg::ctm_tim_brp_w];
				sp  <= pwdata[ctm_pkg::ctm_tim_sp_lsb +: ctm_pkg::ctm_tim_sp_w];
			end
		end
	end

	// ----------------------------------------
	// mode latch
	// ----------------------------------------
	// mode bits only follow while disabled so a live frame is never cut
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			active <= '0;
		end else if (!active[ctm_pkg::ctm_ctrl_enable]) begin
			active <= ctrl;
		end else begin
			active[ctm_pkg::ctm_ctrl_enable] <= ctrl[ctm_pkg::ctm_ctrl_enable];
		end
	end

	// ----------------------------------------
	// test-mode routing
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			can_tx <= 1'b1;
		end else begin
			// silent keeps pin recessive: no frames, no ack
			can_tx <= (silent_mode || !active[ctm_pkg::ctm_ctrl_enable]) ? 1'b1 : core_tx;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			core_rx <= 1'b1;
		end else begin
			// loopback feeds tx back to rx; bus ignored
			core_rx <= loop_mode ? core_tx : can_rx;
		end
	end

	// ----------------------------------------
	// controller core controls
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			core_enable      <= 1'b0;
			core_ack_inhibit <= 1'b0;
			core_retry_abort <= 1'b0;
		end else begin
			core_enable      <= active[ctm_pkg::ctm_ctrl_enable];
			core_ack_inhibit <= silent_mode;
			core_retry_abort <= active[ctm_pkg::ctm_ctrl_oneshot];
		end
	end

	// bit timing reaches the core one cycle after the register
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			core_brp          <= 16'h0000;
			core_sample_point <= 8'h00;
		end else begin
			core_brp          <= brp;
			core_sample_point <= sp;
		end
	end

	// ----------------------------------------
	// transmit tracking: one attempt in one-shot mode
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tx_state <= ctm_pkg::ctm_tx_idle;
		end else begin
			unique case (tx_state)
				ctm_pkg::ctm_tx_idle:
					if (core_tx_req && active[ctm_pkg::ctm_ctrl_enable])
						tx_state <= ctm_pkg::ctm_tx_busy;
				// without one-shot an error keeps the frame busy while the core retries
				ctm_pkg::ctm_tx_busy:
					if (core_tx_ok || (core_tx_err && active[ctm_pkg::ctm_ctrl_oneshot]))
						tx_state <= ctm_pkg::ctm_tx_done;
					else if (!active[ctm_pkg::ctm_ctrl_enable])
						tx_state <= ctm_pkg::ctm_tx_idle;
				ctm_pkg::ctm_tx_done:
					tx_state <= ctm_pkg::ctm_tx_idle;
				default:
					tx_state <= ctm_pkg::ctm_tx_idle;
			endcase
		end
	end

	// ----------------------------------------
	// interrupts: set wins over write-one clear
	// ----------------------------------------
	always_comb begin
		irq_events = '0;
		irq_events[ctm_pkg::ctm_irq_tx_done] = (tx_state == ctm_pkg::ctm_tx_busy) && core_tx_ok;
		irq_events[ctm_pkg::ctm_irq_tx_fail] = (tx_state == ctm_pkg::ctm_tx_busy) && core_tx_err
			&& active[ctm_pkg::ctm_ctrl_oneshot];
		irq_events[ctm_pkg::ctm_irq_err_chg] = (core_err_state != err_prev);
		next_irq_status = irq_status;
		if (wr_take && addr_hit(paddr, ctm_pkg::ctm_off_irq))
			next_irq_status = irq_status & ~pwdata[ctm_pkg::ctm_irq_width-1:0];
		next_irq_status = next_irq_status | irq_events;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irq_status <= '0;
			err_prev   <= 2'b00;
		end else begin
			irq_status <= next_irq_status;
			err_prev   <= core_err_state;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irq_mask <= '0;
		end else if (wr_take && addr_hit(paddr, ctm_pkg::ctm_off_mask)) begin
			irq_mask <= pwdata[ctm_pkg::ctm_irq_width-1:0];
		end
	end

	// ----------------------------------------
	// interrupt output: a set mask bit hides its event
	// ----------------------------------------
	// built from the next status so a new event raises irq without an extra cycle
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_irq_status & ~irq_mask);
		end
	end

	// ----------------------------------------
	// blink generators
	// ----------------------------------------
	// phases run free, so the first blink after a state change may be short
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			fast_cnt   <= '0;
			fast_phase <= 1'b0;
		end else if (fast_cnt == ctm_pkg::ctm_blink_w'(fast_cycles - 1)) begin
			fast_cnt   <= '0;
			fast_phase <= !fast_phase;
		end else begin
			fast_cnt <= fast_cnt + 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			slow_cnt   <= '0;
			slow_phase <= 1'b0;
		end else if (slow_cnt == ctm_pkg::ctm_blink_w'(slow_cycles - 1)) begin
			slow_cnt   <= '0;
			slow_phase <= !slow_phase;
		end else begin
			slow_cnt <= slow_cnt + 1'b1;
		end
	end

	// ----------------------------------------
	// lamps: bus-off and error states outrank activity
	// ----------------------------------------
	always_comb begin
		if (!active[ctm_pkg::ctm_ctrl_enable]) begin
			next_lamp_ready = 1'b0;
			next_lamp_host  = 1'b1;
		end else if (core_err_state == ctm_pkg::ctm_err_busoff) begin
			next_lamp_ready = 1'b0;
			next_lamp_host  = slow_phase;
		end else if (core_err_state == ctm_pkg::ctm_err_passive) begin
			next_lamp_ready = fast_phase;
			next_lamp_host  = 1'b0;
		end else if (core_err_state == ctm_pkg::ctm_err_warning) begin
			next_lamp_ready = slow_phase;
			next_lamp_host  = 1'b0;
		end else if (tx_state == ctm_pkg::ctm_tx_busy) begin
			next_lamp_ready = 1'b1;
			next_lamp_host  = fast_phase;
		end else begin
			next_lamp_ready = 1'b1;
			next_lamp_host  = 1'b0;
		end
	end

	// ----------------------------------------
	// lamp outputs
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			lamp_ready <= 1'b0;
			lamp_host  <= 1'b1;
		end else begin
			lamp_ready <= next_lamp_ready;
			lamp_host  <= next_lamp_host;
		end
	end

endmodule : ctm_mode_ctrl

`default_nettype wire

//--- bench/ctm_bus_node.sv
// Purpose: far CAN node on a wired-AND bus
// Assumes: recessive is 1, dominant 0 wins
// Notes:   bench steers node_tx
`default_nettype none
module ctm_bus_node (
	// bus parties
	input  wire logic node_tx,
	input  wire logic dut_tx,
	// line seen by the block
	output var  logic bus_rx
);
	timeunit 1ns;
	timeprecision 1ps;
	// open-collector line, so a silent block never masks the node
	assign bus_rx = node_tx & dut_tx;
endmodule : ctm_bus_node
`default_nettype wire

//--- bench/ctm_mode_ctrl_assertions.sv
// Purpose: port checks for ctm_mode_ctrl
// Assumes: one clock, sync reset
// Notes:   runs of three cycles absorb the output register lag
`default_nettype none
module ctm_mode_ctrl_assertions #(
	parameter int unsigned fast_cycles = 4,
	parameter int unsigned slow_cycles = 16
) (
	// clock, reset, apb
	input wire logic       ref_clk,
	input wire logic       reset,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	// core, bus, lamps
	input wire logic       core_tx,
	input wire logic [1:0] core_err_state,
	input wire logic       core_enable,
	input wire logic       core_retry_abort,
	input wire logic       core_ack_inhibit,
	input wire logic       can_tx,
	input wire logic       lamp_ready,
	input wire logic       lamp_host
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rdy_run;
	logic [7:0] host_run;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// length of an unchanged lamp; a stuck blinker overruns the bound
	always_ff @(posedge ref_clk) begin
		if (reset || !core_enable || core_err_state != ctm_pkg::ctm_err_passive || $changed(lamp_ready)) begin
			rdy_run <= 8'h00;
		end else begin
			rdy_run <= rdy_run + 8'h01;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (reset || !core_enable || core_err_state != ctm_pkg::ctm_err_busoff || $changed(lamp_host)) begin
			host_run <= 8'h00;
		end else begin
			host_run <= host_run + 8'h01;
		end
	end
	sequence s_live;
		core_enable && !core_ack_inhibit;
	endsequence
	chk_apb_ready: assert property (psel && !penable |=> pready)
		else $error("no pready after setup");
	chk_ready_once: assert property (pready |-> $past(psel) && !$past(penable))
		else $error("pready without setup");
	chk_mode_frozen: assert property (core_enable && $past(core_enable) |-> $stable(core_ack_inhibit) && $stable(core_retry_abort))
		else $error("mode changed while enabled");
	chk_silent_quiet: assert property (core_ack_inhibit [*3] |-> can_tx)
		else $error("silent mode drove the bus");
	chk_tx_follow: assert property (s_live [*3] |-> can_tx == $past(core_tx))
		else $error("bus output not following core");
	chk_lamp_down: assert property ((!core_enable) [*3] |-> can_tx && lamp_host && !lamp_ready)
		else $error("disabled lamps or bus wrong");
	chk_lamp_up: assert property ((core_enable && core_err_state == ctm_pkg::ctm_err_active) [*3] |-> lamp_ready)
		else $error("ready lamp off while up");
	chk_ready_fast: assert property (rdy_run <= 2 * fast_cycles + 4)
		else $error("ready lamp not blinking fast");
	chk_host_slow: assert property (host_run <= 2 * slow_cycles + 4)
		else $error("host lamp not blinking in bus-off");
endmodule : ctm_mode_ctrl_assertions
bind ctm_mode_ctrl ctm_mode_ctrl_assertions #(.fast_cycles(fast_cycles), .slow_cycles(slow_cycles)) i_chk (
	.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pready(pready),
	.core_tx(core_tx), .core_err_state(core_err_state), .core_enable(core_enable),
	.core_retry_abort(core_retry_abort), .core_ack_inhibit(core_ack_inhibit), .can_tx(can_tx),
	.lamp_ready(lamp_ready), .lamp_host(lamp_host)
);
`default_nettype wire

//--- bench/ctm_mode_ctrl_tb_top.sv
// Purpose: self-checking bench for ctm_mode_ctrl
// Assumes: zero-wait APB, a set mask bit masks
// Notes:   blink counts shortened to 4 and 16
`default_nettype none
module ctm_mode_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] a_ctrl = ctm_pkg::ctm_off_ctrl;
	localparam logic [11:0] a_tim  = ctm_pkg::ctm_off_timing;
	localparam logic [11:0] a_stat = ctm_pkg::ctm_off_status;
	localparam logic [11:0] a_irq  = ctm_pkg::ctm_off_irq;
	localparam logic [11:0] a_mask = ctm_pkg::ctm_off_mask;
	logic        ref_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic        pready, pslverr, serr, prev, core_rx, core_enable, core_retry_abort, core_ack_inhibit;
	logic        core_tx = 1'b1, core_tx_req = 1'b0, core_tx_ok = 1'b0, core_tx_err = 1'b0;
	logic [1:0]  core_err_state = 2'b00;
	logic [15:0] core_brp;
	logic [7:0]  core_sample_point;
	logic        can_tx, can_rx, node_tx = 1'b1, lamp_ready, lamp_host, irq;
	logic [31:0] modes [3] = '{32'h3, 32'h5, 32'h7};
	int          error_cnt = 0, compares = 0, cyc = 0, n = 0;
	ctm_mode_ctrl #(.fast_cycles(4), .slow_cycles(16)) i_ctm_mode_ctrl (
		.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_tx(core_tx),
		.core_tx_req(core_tx_req), .core_tx_ok(core_tx_ok), .core_tx_err(core_tx_err),
		.core_err_state(core_err_state), .core_rx(core_rx), .core_enable(core_enable),
		.core_retry_abort(core_retry_abort), .core_ack_inhibit(core_ack_inhibit), .core_brp(core_brp),
		.core_sample_point(core_sample_point), .can_tx(can_tx), .can_rx(can_rx),
		.lamp_ready(lamp_ready), .lamp_host(lamp_host), .irq(irq)
	);
	ctm_bus_node i_ctm_bus_node (.node_tx(node_tx), .dut_tx(can_tx), .bus_rx(can_rx));
	always #2.5 ref_clk = !ref_clk;
	task automatic report_and_stop;
		$display("compares=%0d error_cnt=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop
	// a hung handshake ends here
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			report_and_stop;
		end
	end
	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk);
	endtask : tick
	task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_w
	task automatic chk_b(input logic got, input logic exp);
		chk_w({31'h0, got}, {31'h0, exp});
	endtask : chk_b
	// idle cycle after each transfer keeps psel from being driven twice at one edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		tick(1);
		penable <= 1'b1;
		do tick(1); while (pready !== 1'b1);
		rdat = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		tick(1);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk_w(rdat & m, e);
	endtask : rd
	task automatic txf(input logic good);
		core_tx_req <= 1'b1;
		repeat (20) begin
			prev = lamp_host;
			tick(1);
			n += int'(lamp_host !== prev);
		end
		core_tx_ok <= good;
		core_tx_err <= !good;
		core_tx_req <= 1'b0;
		tick(1);
		core_tx_ok <= 1'b0;
		core_tx_err <= 1'b0;
		tick(2);
	endtask : txf
	// counts lamp changes over k cycles; host picks lamp_host over lamp_ready
	task automatic cnt_chg(input logic host, input int k);
		n = 0;
		repeat (k) begin
			prev = host ? lamp_host : lamp_ready;
			tick(1);
			n += int'((host ? lamp_host : lamp_ready) !== prev);
		end
	endtask : cnt_chg
	initial begin
		tick(4);
		reset <= 1'b0;
		tick(1);
		chk_b(lamp_host, 1'b1);
		chk_b(lamp_ready, 1'b0);
		rd(a_tim, 32'hFFFFFFFF, 32'h00E00640);
		rd(12'h014, 32'hFFFFFFFF, 32'h0);
		chk_b(serr, 1'b1);
		wr(a_tim, 32'h00E00190);
		tick(1);
		chk_w({8'h00, core_sample_point, core_brp}, 32'h00E00190);
		wr(a_ctrl, 32'h1);
		tick(3);
		chk_b(lamp_ready, 1'b1);
		chk_b(lamp_host, 1'b0);
		wr(a_tim, 32'h00E00050);
		rd(a_tim, 32'hFFFFFFFF, 32'h00E00190);
		wr(a_ctrl, 32'h3);
		rd(a_stat, 32'hF, 32'h1);
		wr(a_ctrl, 32'h0);
		tick(3);
		chk_b(lamp_host, 1'b1);
		chk_b(lamp_ready, 1'b0);
		foreach (modes[i]) begin
			wr(a_ctrl, modes[i]);
			core_tx <= 1'b0;
			tick(3);
			chk_b(can_tx, modes[i][2]);
			chk_b(core_rx, !modes[i][1]);
			chk_b(core_ack_inhibit, modes[i][2]);
			rd(a_stat, 32'hF, modes[i]);
			core_tx <= 1'b1;
			wr(a_ctrl, 32'h0);
			tick(2);
		end
		wr(a_mask, 32'h0);
		wr(a_ctrl, 32'h9);
		tick(2);
		chk_b(core_retry_abort, 1'b1);
		txf(1'b1);
		chk_b(n != 0, 1'b1);
		rd(a_irq, 32'h7, 32'h1);
		txf(1'b0);
		rd(a_stat, 32'h30, 32'h00);
		rd(a_irq, 32'h7, 32'h3);
		chk_b(irq, 1'b1);
		wr(a_mask, 32'h7);
		tick(1);
		chk_b(irq, 1'b0);
		wr(a_irq, 32'h3);
		wr(a_mask, 32'h0);
		rd(a_irq, 32'h7, 32'h0);
		chk_b(irq, 1'b0);
		core_err_state <= 2'b11;
		tick(8);
		rd(a_irq, 32'h4, 32'h4);
		cnt_chg(1'b0, 32);
		chk_b(n >= 7, 1'b1);
		core_err_state <= 2'b01;
		tick(2);
		cnt_chg(1'b0, 32);
		chk_b(n >= 1 && n <= 3, 1'b1);
		core_err_state <= 2'b10;
		tick(2);
		cnt_chg(1'b1, 64);
		chk_b(n >= 3 && n <= 5, 1'b1);
		report_and_stop;
	end
endmodule : ctm_mode_ctrl_tb_top
`default_nettype wire
